// ---- rsc_field.sv ----
/*
  Far-side model: series circuit, output current transformer, phase
  reference and remote control system.
  Assumes the controller clock and a shortened half cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_field
  import rsc_pkg::*;
#(
  parameter int HALF = 200
) (
  input wire logic clk,
  input wire logic contactor,
  input wire logic relay,
  input wire logic [MV_W-1:0] load_mv,
  input wire logic [2:0] rem_code,
  output logic [MV_W-1:0] fb_mv,
  output logic fb_vld,
  output logic zc,
  output logic [2:0] rem_cmd
);
  int t = 0;
  initial begin
    fb_mv = '0;
    fb_vld = 1'b0;
    zc = 1'b0;
  end
  // Remote inputs see a command only while the remote supply is applied.
  assign rem_cmd = relay ? rem_code : 3'h0;
  //////////////////////////////////////////////////////////////////////
  // Samples every fourth cycle; between samples the bus toggles.
  always @(posedge clk) begin
    t <= t + 1;
    zc <= (t % HALF) < 4;
    fb_vld <= (t % 4) == 0;
    fb_mv <= ((t % 4) == 0) ? (contactor ? load_mv : '0) : ~fb_mv;
  end
endmodule
`default_nettype wire

// ---- rsc_gate.sv ----
/*
  Thyristor firing control: phase delay after each zero cross, trimmed
  toward the target feedback level on every sample outside the deadband.
  Assumes zc is a synchronised one-cycle pulse per half cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_gate
  import rsc_pkg::*;
#(
  parameter int HALF = HALF_CYC,
  parameter int FIRE = FIRE_CYC,
  parameter logic [DLY_W-1:0] STEP = 22'h00_0400
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic zc,
  input wire logic smp_vld,
  input wire logic [MV_W-1:0] meas_mv,
  input wire logic [MV_W-1:0] target_mv,
  output logic gate_q
);
  logic [DLY_W-1:0] dly_q, dly_d, cnt_q, cnt_d;
  logic gate_d;
  logic [MV_W-1:0] band;
  initial begin
    if (HALF + int'(STEP) >= (1 << DLY_W) || FIRE < 1 || FIRE >= HALF)
      $error("rsc_gate: timing parameters out of range.");
  end
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    band = target_mv >> 7;
    dly_d = dly_q;
    cnt_d = cnt_q;
    gate_d = 1'b0;
    if (!en) begin
      dly_d = '0;
      cnt_d = '0;
    end else begin
      // Later firing raises the output of the resonant network.
      if (smp_vld && meas_mv + band < target_mv && dly_q + STEP < DLY_W'(HALF - FIRE)) begin
        dly_d = dly_q + STEP; // RULE_10 RULE_14
      end else if (smp_vld && meas_mv > target_mv + band && dly_q >= STEP) begin
        dly_d = dly_q - STEP; // RULE_10 RULE_14
      end
      cnt_d = zc ? '0 : (cnt_q < DLY_W'(HALF) ? cnt_q + 1'b1 : cnt_q);
      gate_d = cnt_q >= dly_q && cnt_q < dly_q + DLY_W'(FIRE); // RULE_10
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dly_q <= '0;
      cnt_q <= '0;
      gate_q <= 1'b0;
    end else begin
      dly_q <= dly_d;
      cnt_q <= cnt_d;
      gate_q <= gate_d;
    end
  end
  gate_off_a: assert property (@(posedge clk) disable iff (!rstn) !en |=> !gate_q) // RULE_15
    else $error("Gate drive active while disabled.");
endmodule
`default_nettype wire

// ---- rsc_pkg.sv ----
/*
  Shared constants, register map, types and timing for the regulator
  supervisory controller.
  Assumes a 250 MHz system clock.
*/
`default_nettype none
package rsc_pkg;
  // Timing.
  localparam int CLK_HZ = 250_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int PWR_OFF_MS = 2000;
  localparam int PWR_OFF_CYC = CYC_PER_MS * PWR_OFF_MS;
  localparam int OPEN_MS = 1000;
  localparam int OPEN_CYC = CYC_PER_MS * OPEN_MS;
  localparam int OVER_MS = 20;
  localparam int OVER_CYC = CYC_PER_MS * OVER_MS;
  localparam int FIRE_US = 10;
  localparam int FIRE_CYC = CYC_PER_US * FIRE_US;
  localparam int HALF_US = 8333;
  localparam int HALF_CYC = CYC_PER_US * HALF_US;
  localparam int CNT_W = 32;
  localparam int DLY_W = 22;
  // Feedback scaling.
  localparam int MV_W = 12;
  localparam int SHUNT_OHM = 15;
  localparam int OPEN_MA = 1500;
  localparam int RATIO_LO = 100;
  localparam int RATIO_HI = 300;
  localparam logic [11:0] OPEN_MV_LO = 12'(OPEN_MA * SHUNT_OHM / RATIO_LO);
  localparam logic [11:0] OPEN_MV_HI = 12'(OPEN_MA * SHUNT_OHM / RATIO_HI);
  localparam logic [11:0] STEP1_MV = 12'h1A4;
  localparam logic [11:0] STEP2_MV = 12'h1FE;
  localparam logic [11:0] STEP3_MV = 12'h267;
  localparam logic [11:0] STEP4_MV = 12'h30C;
  localparam logic [11:0] STEP5_MV = 12'h3DE;
  localparam logic [2:0] STEPS_3 = 3'h3;
  localparam logic [2:0] STEPS_5 = 3'h5;
  // Switch codes.
  localparam logic [2:0] SW_OFF = 3'h0;
  localparam logic [2:0] SW_REMOTE = 3'h7;
  // Register map, byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_OVER_LIM = 8'h10;
  localparam logic [7:0] REG_TRIM = 8'h14;
  localparam int CTRL_STYLE5 = 0;
  localparam int CTRL_RATIO_HI = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [11:0] OVER_LIM_RST = 12'h44C;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam int INT_W = 4;
  localparam int INT_OVER = 0;
  localparam int INT_OPEN = 1;
  localparam int INT_CLEAR = 2;
  localparam int INT_MODE = 3;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rsc_bus_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_FAULT = 3'b100
  } rsc_state_t;
endpackage
`default_nettype wire

// ---- rsc_sync.sv ----
/*
  Two-stage synchroniser, one per bit.
  Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  initial begin
    if (W < 1) $error("rsc_sync: W must be at least 1.");
  end
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rstn) begin
        s1_q[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        s1_q[i] <= din[i];
        dout[i] <= s1_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// ---- rsc_top.sv ----
/*
  Supervisory controller: local or remote step selection, contactor and
  remote-supply relay drive, fault latching, thyristor firing and an
  Avalon-MM register slave with interrupt.
  Assumes feedback samples in millivolts arrive on the clk domain, and
  switch, remote, phase and power pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01: Overcurrent above limit opens the contactor.
// RULE_02: Only sustained overcurrent trips the shutdown.
// RULE_03: Fault latch cleared by OFF or power cycle.
// RULE_04: Below 1.5 A is open circuit, latched.
// RULE_05: Open circuit drops contactor within one second.
// RULE_06: Open or shorted transformer also trips.
// RULE_07: Remote inputs obeyed only in remote position.
// RULE_08: Remote position closes the remote supply relay.
// RULE_09: Contactor on only when running without fault.
// RULE_10: Gate drive regulates current to the step.
// RULE_11: Feedback ratio 100:1 or 300:1 selectable.
// RULE_12: Step targets 420 to 990 millivolts.
// RULE_13: Three or five steps per style.
// RULE_14: Loop holds current within one percent.
// RULE_15: Fault suppresses gates, ignores non-OFF commands.
module rsc_top
  import rsc_pkg::*;
#(
  parameter int PWR_OFF = PWR_OFF_CYC,
  parameter int OPEN_FILT = OPEN_CYC,
  parameter int OVER_FILT = OVER_CYC,
  parameter int HALF = HALF_CYC,
  parameter int FIRE = FIRE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] sw_pos_pin,
  input wire logic [2:0] rem_cmd_pin,
  input wire logic phase_zc_pin,
  input wire logic pwr_ok_pin,
  input wire logic [MV_W-1:0] fb_mv,
  input wire logic fb_vld,
  output logic main_input_contactor_drv,
  output logic remote_supply_relay_drv,
  output logic gate_drv,
  output logic irq
);
  initial begin
    if (PWR_OFF < 2 || OPEN_FILT < 2 || OVER_FILT < 2)
      $error("rsc_top: filter counts must be at least 2.");
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and zero-cross edge.
  logic [2:0] sw_pos, rem_cmd;
  logic zc_s, pwr_ok, zc_prev_q, zc_pulse;
  rsc_sync #(.W(8)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({sw_pos_pin, rem_cmd_pin, phase_zc_pin, pwr_ok_pin}),
    .dout({sw_pos, rem_cmd, zc_s, pwr_ok})
  );
  always_ff @(posedge clk) begin
    if (!rstn) begin
      zc_prev_q <= 1'b0;
    end else begin
      zc_prev_q <= zc_s;
    end
  end
  assign zc_pulse = zc_s && !zc_prev_q;
  ////////////////////////////////////////////////////////////////////
  // Register bus.
  rsc_bus_t bus;
  logic [1:0] ctrl_q, ctrl_d;
  logic [11:0] lim_q, lim_d;
  logic [7:0] trim_q, trim_d;
  logic [INT_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic ack_q, ack_d;
  logic [31:0] rdata_d;
  logic wr, rd;
  rsc_state_t st_q, st_d;
  logic [2:0] step_q, step_d;
  logic fault_over_q, fault_over_d, fault_open_q, fault_open_d;
  logic remote_q, remote_d;
  assign bus = '{read: avs_read, write: avs_write, addr: avs_address, wdata: avs_writedata};
  assign avs_waitrequest = (bus.read || bus.write) && !ack_q;
  assign wr = bus.write && ack_q;
  assign rd = bus.read && !ack_q;
  always_comb begin
    ctrl_d = ctrl_q;
    lim_d = lim_q;
    trim_d = trim_q;
    imask_d = imask_q;
    ist_d = ist_q;
    ack_d = (bus.read || bus.write) && !ack_q;
    rdata_d = '0;
    if (wr) begin
      unique case ({bus.addr[7:2], 2'b00})
        REG_CTRL: ctrl_d = bus.wdata[1:0];
        REG_INT_STAT: ist_d = ist_q & ~bus.wdata[INT_W-1:0];
        REG_INT_MASK: imask_d = bus.wdata[INT_W-1:0];
        REG_OVER_LIM: lim_d = bus.wdata[11:0];
        REG_TRIM: trim_d = bus.wdata[7:0];
        default: ;
      endcase
    end
    ist_d = ist_d | ev;
    if (rd) begin
      unique case ({bus.addr[7:2], 2'b00})
        REG_CTRL: rdata_d = {30'h0, ctrl_q};
        REG_STATUS: rdata_d = {22'h0, pwr_ok, st_q, step_q, remote_q,
                               fault_open_q, fault_over_q};
        REG_INT_STAT: rdata_d = {28'h0, ist_q};
        REG_INT_MASK: rdata_d = {28'h0, imask_q};
        REG_OVER_LIM: rdata_d = {20'h0, lim_q};
        REG_TRIM: rdata_d = {24'h0, trim_q};
        default: rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
      lim_q <= OVER_LIM_RST;
      trim_q <= TRIM_RST;
      ist_q <= '0;
      imask_q <= '0;
      ack_q <= 1'b0;
      avs_readdata <= '0;
      irq <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      lim_q <= lim_d;
      trim_q <= trim_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      ack_q <= ack_d;
      avs_readdata <= rd ? rdata_d : avs_readdata;
      irq <= |(ist_d & imask_d);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Command selection.
  logic [2:0] cmd, max_step, step_sel;
  logic cmd_off, is_remote;
  always_comb begin
    is_remote = sw_pos == SW_REMOTE; // RULE_07
    cmd = is_remote ? rem_cmd : sw_pos; // RULE_07
    max_step = ctrl_q[CTRL_STYLE5] ? STEPS_5 : STEPS_3; // RULE_13
    cmd_off = cmd == SW_OFF || cmd == SW_REMOTE;
    step_sel = cmd > max_step ? max_step : cmd; // RULE_13
  end
  ////////////////////////////////////////////////////////////////////
  // Fault filters and power-cycle detection.
  logic [MV_W-1:0] fb_q, fb_d, open_mv;
  logic [CNT_W-1:0] over_cnt_q, over_cnt_d, open_cnt_q, open_cnt_d;
  logic [CNT_W-1:0] pwr_cnt_q, pwr_cnt_d;
  logic trip_over, trip_open, pwr_cycled;
  always_comb begin
    fb_d = fb_vld ? fb_mv : fb_q;
    open_mv = ctrl_q[CTRL_RATIO_HI] ? OPEN_MV_HI : OPEN_MV_LO; // RULE_11
    over_cnt_d = '0;
    open_cnt_d = '0;
    if (st_q == ST_RUN && fb_q > lim_q) begin
      over_cnt_d = over_cnt_q + 1'b1; // RULE_02
    end
    // No feedback also covers an open or shorted current transformer.
    if (st_q == ST_RUN && fb_q < open_mv) begin
      open_cnt_d = open_cnt_q + 1'b1; // RULE_04 RULE_06
    end
    trip_over = over_cnt_q >= CNT_W'(OVER_FILT - 1) && fb_q > lim_q; // RULE_01 RULE_02
    trip_open = open_cnt_q >= CNT_W'(OPEN_FILT - 1) && fb_q < open_mv; // RULE_05
    pwr_cnt_d = pwr_ok ? '0 :
                (pwr_cnt_q < CNT_W'(PWR_OFF) ? pwr_cnt_q + 1'b1 : pwr_cnt_q);
    pwr_cycled = pwr_ok && pwr_cnt_q >= CNT_W'(PWR_OFF); // RULE_03
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fb_q <= '0;
      over_cnt_q <= '0;
      open_cnt_q <= '0;
      pwr_cnt_q <= '0;
    end else begin
      fb_q <= fb_d;
      over_cnt_q <= over_cnt_d;
      open_cnt_q <= open_cnt_d;
      pwr_cnt_q <= pwr_cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Supervisory state machine.
  logic contactor_d;
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    fault_over_d = fault_over_q;
    fault_open_d = fault_open_q;
    remote_d = is_remote;
    ev = '0;
    unique case (st_q)
      ST_OFF: begin
        step_d = cmd_off ? 3'h0 : step_sel;
        if (!cmd_off) st_d = ST_RUN;
      end
      ST_RUN: begin
        step_d = cmd_off ? 3'h0 : step_sel;
        if (trip_over || trip_open) begin
          st_d = ST_FAULT; // RULE_01 RULE_04
          step_d = 3'h0; // RULE_15
          fault_over_d = trip_over;
          fault_open_d = trip_open;
        end else if (cmd_off) begin
          st_d = ST_OFF;
        end
      end
      ST_FAULT: begin
        // Step commands are held off until the latch clears.
        if (cmd_off || pwr_cycled) begin
          st_d = ST_OFF; // RULE_03 RULE_15
          step_d = 3'h0;
          fault_over_d = 1'b0;
          fault_open_d = 1'b0;
          ev[INT_CLEAR] = 1'b1;
        end
      end
      default: st_d = ST_OFF;
    endcase
    ev[INT_OVER] = st_q == ST_RUN && trip_over;
    ev[INT_OPEN] = st_q == ST_RUN && trip_open;
    ev[INT_MODE] = remote_q != is_remote;
    contactor_d = st_d == ST_RUN; // RULE_09
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= ST_OFF;
      step_q <= 3'h0;
      fault_over_q <= 1'b0;
      fault_open_q <= 1'b0;
      remote_q <= 1'b0;
      main_input_contactor_drv <= 1'b0;
      remote_supply_relay_drv <= 1'b0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      fault_over_q <= fault_over_d;
      fault_open_q <= fault_open_d;
      remote_q <= remote_d;
      main_input_contactor_drv <= contactor_d; // RULE_09
      remote_supply_relay_drv <= is_remote; // RULE_08
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Regulation target and firing.
  logic [MV_W-1:0] base_mv, target_mv;
  always_comb begin
    unique case (step_q)
      3'h1: base_mv = STEP1_MV; // RULE_12
      3'h2: base_mv = STEP2_MV;
      3'h3: base_mv = STEP3_MV;
      3'h4: base_mv = STEP4_MV;
      3'h5: base_mv = STEP5_MV;
      default: base_mv = '0;
    endcase
    target_mv = base_mv + {{4{trim_q[7]}}, trim_q}; // RULE_14
  end
  rsc_gate #(.HALF(HALF), .FIRE(FIRE)) u_gate (
    .clk(clk),
    .rstn(rstn),
    .en(st_q == ST_RUN && main_input_contactor_drv), // RULE_15
    .zc(zc_pulse),
    .smp_vld(fb_vld),
    .meas_mv(fb_q),
    .target_mv(target_mv),
    .gate_q(gate_drv)
  );
  ////////////////////////////////////////////////////////////////////
  // Checks.
  over_trip_a: assert property ((st_q == ST_RUN && trip_over) |=> st_q == ST_FAULT ##1 !main_input_contactor_drv) // RULE_01
    else $error("Overcurrent did not shut down.");
  over_filter_a: assert property ((st_q != ST_RUN) |=> over_cnt_q == '0) // RULE_02
    else $error("Overcurrent filter counted outside run.");
  fault_hold_a: assert property ((st_q == ST_FAULT && !cmd_off && !pwr_cycled) |=> st_q == ST_FAULT && !main_input_contactor_drv) // RULE_03
    else $error("Fault latch released without reset.");
  fault_clear_a: assert property ((st_q == ST_FAULT && cmd_off) |=> st_q == ST_OFF && !fault_over_q && !fault_open_q) // RULE_03
    else $error("OFF did not clear the fault latch.");
  open_trip_a: assert property ((st_q == ST_RUN && trip_open) |=> fault_open_q ##1 !main_input_contactor_drv) // RULE_04
    else $error("Open circuit did not latch shutdown.");
  open_bound_a: assert property (open_cnt_q <= CNT_W'(OPEN_FILT)) // RULE_05
    else $error("Open circuit outlived its time bound.");
  remote_sel_a: assert property ((st_q == ST_OFF && !is_remote && sw_pos == SW_OFF) |=> st_q == ST_OFF) // RULE_07
    else $error("Remote input acted in local position.");
  relay_a: assert property (is_remote |=> remote_supply_relay_drv) // RULE_08
    else $error("Remote supply relay not closed.");
  contactor_a: assert property ((fault_over_q || fault_open_q) |-> !contactor_d) // RULE_09
    else $error("Contactor driven with fault latched.");
  step_cap_a: assert property (step_q <= max_step || $changed(ctrl_q)) // RULE_13
    else $error("Step above style limit.");
  fault_gate_a: assert property ((st_q == ST_FAULT) |=> !gate_drv) // RULE_15
    else $error("Gate drive during fault.");
endmodule
`default_nettype wire

// ---- rsc_top_tb.sv ----
/*
  Self-checking bench for the supervisory controller.
  Assumes shortened filter and power-cycle parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb
  import rsc_pkg::*;
;
  localparam int HF = 200;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic wt;
  logic [2:0] sw = '0;
  logic [2:0] rem = '0;
  logic [2:0] rcmd;
  logic pok = 1'b1;
  logic [11:0] load = '0;
  logic [11:0] fb;
  logic fv, zc, con, rel, gd, irq;
  logic [3:0] outs;
  logic [31:0] lfsr = 32'h0001_38B0;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int error_cnt = 0;
  int check_count = 0;
  assign outs = {irq, gd, rel, con};
  rsc_top #(.PWR_OFF(50), .OPEN_FILT(40), .OVER_FILT(20), .HALF(HF), .FIRE(10)) i_rsc_top (
    .clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
    .sw_pos_pin(sw), .rem_cmd_pin(rcmd), .phase_zc_pin(zc), .pwr_ok_pin(pok),
    .fb_mv(fb), .fb_vld(fv), .main_input_contactor_drv(con),
    .remote_supply_relay_drv(rel), .gate_drv(gd), .irq(irq));
  rsc_field #(.HALF(HF)) i_rsc_field (.clk(clk), .contactor(con), .relay(rel),
    .load_mv(load), .rem_code(rem), .fb_mv(fb), .fb_vld(fv), .zc(zc), .rem_cmd(rcmd));
  //////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] stat(input logic [2:0] s, input logic [2:0] st,
                                       input logic r, input logic [1:0] f);
    return {22'h0, pok, s, st, r, f};
  endfunction
  //////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (wt !== 1'b0) error_cnt++;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hFFFF_FFFF);
    eq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_pin(input int s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (outs[s] !== v && n < lim);
    check(32'(outs[s]), 32'(v));
    @(posedge clk);
  endtask
  task automatic hold_pin(input int s, input logic v, input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (outs[s] !== v) bad++;
    end
    check(32'(bad), 32'h0000_0000);
    @(posedge clk);
  endtask
  // Read results are compared against the oldest noted expectation.
  always @(posedge clk) begin
    if (rd && wt === 1'b0 && eq.size() > 0) begin
      check(rdat & mq[0], eq[0] & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    int g;
    g = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(REG_CTRL, {30'h0, CTRL_RST});
    rd_chk(REG_STATUS, stat(ST_OFF, 3'h0, 1'b0, 2'h0));
    rd_chk(REG_INT_MASK, 32'h0000_0000);
    rd_chk(REG_OVER_LIM, {20'h0, OVER_LIM_RST});
    rd_chk(REG_TRIM, {24'h0, TRIM_RST});
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0000_0000);
    repeat (3) begin
      lfsr = nxt(lfsr);
      bus(1'b1, REG_TRIM, lfsr);
      rd_chk(REG_TRIM, {24'h0, lfsr[7:0]});
      bus(1'b1, REG_OVER_LIM, lfsr);
      rd_chk(REG_OVER_LIM, {20'h0, lfsr[11:0]});
    end
    bus(1'b1, REG_TRIM, 32'h0000_0000);
    bus(1'b1, REG_OVER_LIM, {20'h0, OVER_LIM_RST});
    bus(1'b1, REG_INT_MASK, 32'h0000_0003);
    load <= STEP3_MV;
    sw <= 3'h3;
    wait_pin(0, 1'b1, 10);
    rd_chk(REG_STATUS, stat(ST_RUN, 3'h3, 1'b0, 2'h0));
    check(32'(rel), 32'h0000_0000);
    repeat (3 * HF) begin
      @(negedge clk);
      if (gd === 1'b1) g++;
    end
    @(posedge clk);
    check(32'(g > 0), 32'h0000_0001);
    load <= 12'h0C8;
    hold_pin(0, 1'b1, 36);
    wait_pin(0, 1'b0, 60);
    rd_chk(REG_STATUS, stat(ST_FAULT, 3'h0, 1'b0, 2'h2), 32'h0000_03C7);
    wait_pin(3, 1'b1, 5);
    rd_chk(REG_INT_STAT, 32'h0000_0002);
    hold_pin(2, 1'b0, 2 * HF);
    sw <= 3'h5;
    hold_pin(0, 1'b0, 20);
    bus(1'b1, REG_INT_STAT, 32'h0000_0002);
    wait_pin(3, 1'b0, 5);
    load <= STEP5_MV;
    sw <= 3'h0;
    repeat (6) @(posedge clk);
    rd_chk(REG_INT_STAT, 32'h0000_0004);
    check(32'(irq), 32'h0000_0000);
    sw <= 3'h5;
    wait_pin(0, 1'b1, 10);
    load <= 12'h4B0;
    repeat (6) @(posedge clk);
    load <= STEP5_MV;
    hold_pin(0, 1'b1, 40);
    load <= 12'h4B0;
    hold_pin(0, 1'b1, 16);
    wait_pin(0, 1'b0, 40);
    rd_chk(REG_STATUS, stat(ST_FAULT, 3'h0, 1'b0, 2'h1), 32'h0000_03C7);
    load <= STEP5_MV;
    pok <= 1'b0;
    repeat (20) @(posedge clk);
    pok <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_0001, 32'h0000_0003);
    pok <= 1'b0;
    repeat (60) @(posedge clk);
    pok <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_0000, 32'h0000_0003);
    sw <= 3'h0;
    repeat (6) @(posedge clk);
    sw <= 3'h7;
    rem <= 3'h4;
    wait_pin(1, 1'b1, 10);
    wait_pin(0, 1'b1, 10);
    rd_chk(REG_STATUS, stat(ST_RUN, 3'h4, 1'b1, 2'h0));
    rd_chk(REG_INT_STAT, 32'h0000_0008, 32'h0000_0008);
    rem <= 3'h7;
    wait_pin(0, 1'b0, 10);
    sw <= 3'h2;
    rem <= 3'h5;
    wait_pin(1, 1'b0, 10);
    rd_chk(REG_STATUS, stat(ST_RUN, 3'h2, 1'b0, 2'h0));
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    sw <= 3'h5;
    load <= 12'h064;
    hold_pin(0, 1'b1, 100);
    rd_chk(REG_STATUS, stat(ST_RUN, 3'h3, 1'b0, 2'h0));
    end_of_test;
  end
  initial begin
    #80000;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
